// file: bench/cam_decode_sva.sv
// Concurrent checks on the ports of the operand addressing decoder
`timescale 1ns/100ps
module cam_decode_sva
    import cam_pkg::*;
(
    input wire logic        CLK_I, SYS_RST_I, START_I, RMW_I, USE_Y_I, IRQ_I,
    input wire logic [15:0] PC_I,
    input wire cam_mode_e   MODE_I,
    input wire cam_kind_e   KIND_I,
    input wire logic [7:0]  X_I, Y_I, MEM_DATA_I, OPERAND_O,
    input wire logic        BUSY_O, MEM_RD_O, MEM_ACK_I, DONE_O, ILLEGAL_O,
    input wire logic        OPERAND_VLD_O, SLEEP_O, OSC_STOP_O,
    input wire logic [15:0] MEM_ADDR_O, EA_O, NEXT_PC_O,
    input wire logic [2:0]  LEN_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic        take;
    cam_mode_e   mode_q;
    logic [15:0] pc_q;
    logic [1:0]  nrd_q;
    assign take = START_I && !BUSY_O;
    // Mode and read count of the decode in flight, for checks after the take edge
    always_ff @(posedge CLK_I) begin
        if (take) begin
            mode_q <= MODE_I;
            pc_q   <= PC_I;
            nrd_q  <= 2'h0;
        end else if (MEM_RD_O && MEM_ACK_I) begin
            nrd_q <= nrd_q + 2'h1;
        end
    end
    sequence fetch1;
        MEM_RD_O && MEM_ACK_I;
    endsequence
    sequence asleep;
        SLEEP_O && !IRQ_I;
    endsequence
    inh_len_a: assert property (take && MODE_I == CAM_MODE_INHERENT && KIND_I == CAM_KIND_NORMAL
        |=> DONE_O && !MEM_RD_O && LEN_O == CAM_LEN_INHERENT) else $error("inherent length");
    imm_fetch_a: assert property (take && MODE_I == CAM_MODE_IMMEDIATE |=> ##[0:8] fetch1
        ##1 DONE_O && OPERAND_VLD_O && OPERAND_O == $past(MEM_DATA_I)) else $error("immediate");
    noofs_ea_a: assert property (take && MODE_I == CAM_MODE_NOOFS_IDX && !RMW_I |=> DONE_O
        && EA_O == {8'h00, $past(USE_Y_I) ? $past(Y_I) : $past(X_I)}) else $error("no offset");
    noofs_len_a: assert property (take && MODE_I == CAM_MODE_NOOFS_IDX && !RMW_I
        |=> LEN_O == 3'h1 + {2'h0, $past(USE_Y_I)}) else $error("no offset length");
    rmw_refuse_a: assert property (take && RMW_I && MODE_I inside {CAM_MODE_LONG_DIR,
        CAM_MODE_LONG_IDX, CAM_MODE_LONG_IND} |=> DONE_O && ILLEGAL_O && !MEM_RD_O)
        else $error("long rmw accepted");
    page_zero_a: assert property (DONE_O && mode_q inside {CAM_MODE_SHORT_DIR, CAM_MODE_SHORT_IND}
        |-> EA_O[15:8] == CAM_PAGE0_HIGH) else $error("short ea off page zero");
    short_idx_a: assert property (DONE_O && mode_q == CAM_MODE_SHORT_IDX
        |-> EA_O <= CAM_SHORT_IDX_LAST) else $error("short indexed range");
    first_fetch_a: assert property (MEM_RD_O && nrd_q == 2'h0
        |-> MEM_ADDR_O == pc_q + CAM_OFS_BYTE1) else $error("first fetch address");
    ptr_page0_a: assert property (MEM_RD_O && nrd_q != 2'h0 && mode_q inside {CAM_MODE_SHORT_IND,
        CAM_MODE_LONG_IND, CAM_MODE_REL_IND} |-> MEM_ADDR_O[15:8] == CAM_PAGE0_HIGH)
        else $error("pointer not in page zero");
    sleep_hold_a: assert property (asleep |=> SLEEP_O) else $error("sleep left early");
    sleep_wake_a: assert property ($rose(IRQ_I) && (SLEEP_O || OSC_STOP_O)
        |=> DONE_O && !SLEEP_O && !OSC_STOP_O) else $error("no wake");
    halt_stop_a: assert property (take && MODE_I == CAM_MODE_INHERENT && KIND_I == CAM_KIND_HALT
        |=> OSC_STOP_O) else $error("halt without stop");
endmodule
bind cam_decode cam_decode_sva i_sva (.*);

// file: bench/cam_mem_model.sv
// Behavioural program and data memory answering the decoder's reads
`timescale 1ns/100ps
module cam_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [1:0]  dly_i,
    output logic             ack_o,
    output logic [7:0]       data_o
);
    logic [1:0] wait_q;
    logic [7:0] last_q;
    function automatic logic [7:0] dat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    // Answer after dly_i wait cycles, so both prompt and slow replies occur
    assign ack_o  = rd_i && (wait_q == dly_i);
    // Outside an answer the bus shows junk, never the last byte
    assign data_o = ack_o ? dat(addr_i) : ~last_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !rd_i || ack_o) begin
            wait_q <= 2'h0;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
        if (rst_i) begin
            last_q <= 8'hA5;
        end else if (ack_o) begin
            last_q <= data_o;
        end
    end
endmodule

// file: bench/tb_cpu_addressing_mode_decode.sv
// Self-checking bench for the operand addressing decoder
`timescale 1ns/100ps
module tb_cpu_addressing_mode_decode;
    import cam_pkg::*;
    logic        clk, rst, start, rmw, usey, irq, busy, rd, ack, done, ill, opv, slp, oscs;
    logic [15:0] pc, addr, ea, npc, b;
    logic [7:0]  xr, yr, rdata, opnd;
    logic [2:0]  len;
    logic [1:0]  dly;
    cam_mode_e   mode;
    cam_kind_e   kind;
    int          fails, n_checks, cyc, nrd, n_ill, n_opv, n_pwr;
    cam_decode i_dut (.CLK_I(clk), .SYS_RST_I(rst), .START_I(start), .PC_I(pc), .MODE_I(mode),
        .KIND_I(kind), .RMW_I(rmw), .USE_Y_I(usey), .X_I(xr), .Y_I(yr), .IRQ_I(irq),
        .BUSY_O(busy), .MEM_ADDR_O(addr), .MEM_RD_O(rd), .MEM_ACK_I(ack), .MEM_DATA_I(rdata),
        .DONE_O(done), .ILLEGAL_O(ill), .LEN_O(len), .EA_O(ea), .OPERAND_O(opnd),
        .OPERAND_VLD_O(opv), .NEXT_PC_O(npc), .SLEEP_O(slp), .OSC_STOP_O(oscs));
    cam_mem_model i_mem (.clk_i(clk), .rst_i(rst), .rd_i(rd), .addr_i(addr), .dly_i(dly),
        .ack_o(ack), .data_o(rdata));
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] md(input logic [15:0] a);
        return i_mem.dat(a);
    endfunction
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Start one decode and wait for its end, counting reads and pulses
    task automatic go(input cam_mode_e m, input cam_kind_e k, input logic r, input logic [15:0] p);
        int n;
        mode <= m;
        kind <= k;
        rmw <= r;
        pc <= p;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        nrd = 0;
        n_ill = 0;
        n_opv = 0;
        n_pwr = 0;
        do begin
            @(posedge clk);
            n++;
            if (rd === 1'b1 && ack === 1'b1) nrd++;
            if (ill === 1'b1) n_ill++;
            if (opv === 1'b1) n_opv++;
            if (slp === 1'b1 || oscs === 1'b1) n_pwr++;
            if (n == 5 && kind != CAM_KIND_NORMAL) irq <= 1'b1;
            if (n == 6) irq <= 1'b0;
        end while (done !== 1'b1 && n < 40);
        chk(16'h1, 16'(done));
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_plain;
        go(CAM_MODE_INHERENT, CAM_KIND_NORMAL, 1'b0, 16'h0100);
        chk(16'h1, 16'(len));
        chk(16'h0, 16'(nrd));
        go(CAM_MODE_IMMEDIATE, CAM_KIND_NORMAL, 1'b0, 16'h1000);
        chk(16'h2, 16'(len));
        chk({8'h00, md(16'h1001)}, {8'h00, opnd});
        chk(16'h1, 16'(n_opv));
        chk(16'h1002, npc);
    endtask
    task automatic t_direct;
        go(CAM_MODE_SHORT_DIR, CAM_KIND_NORMAL, 1'b0, 16'h2000);
        chk({8'h00, md(16'h2001)}, ea);
        chk(16'h1, 16'(nrd));
        dly <= 2'h2;
        go(CAM_MODE_LONG_DIR, CAM_KIND_NORMAL, 1'b0, 16'h2100);
        chk({md(16'h2101), md(16'h2102)}, ea);
        chk(16'h3, 16'(len));
        dly <= 2'h0;
    endtask
    task automatic t_indexed;
        xr <= 8'hFF;
        yr <= 8'h80;
        go(CAM_MODE_NOOFS_IDX, CAM_KIND_NORMAL, 1'b0, 16'h0200);
        chk(16'h00FF, ea);
        chk(16'h1, 16'(len));
        usey <= 1'b1;
        go(CAM_MODE_NOOFS_IDX, CAM_KIND_NORMAL, 1'b0, 16'h0200);
        chk(16'h0080, ea);
        chk(16'h2, 16'(len));
        go(CAM_MODE_LONG_IDX, CAM_KIND_NORMAL, 1'b0, 16'h3000);
        chk({md(16'h3001), md(16'h3002)} + 16'h0080, ea);
        usey <= 1'b0;
        go(CAM_MODE_SHORT_IDX, CAM_KIND_NORMAL, 1'b0, 16'h00C2);
        chk(16'h01FE, ea);
    endtask
    task automatic t_indirect;
        dly <= 2'h1;
        b = {8'h00, md(16'h4001)};
        go(CAM_MODE_SHORT_IND, CAM_KIND_NORMAL, 1'b0, 16'h4000);
        chk({8'h00, md(b)}, ea);
        chk(16'h2, 16'(nrd));
        go(CAM_MODE_LONG_IND, CAM_KIND_NORMAL, 1'b0, 16'h4181);
        chk({md(16'h00FF), md(16'h0000)}, ea);
        chk(16'h3, 16'(nrd));
        dly <= 2'h0;
    endtask
    task automatic t_relative;
        b = {8'h00, md(16'h5081)};
        go(CAM_MODE_REL_DIR, CAM_KIND_NORMAL, 1'b0, 16'h5080);
        chk(16'h2, 16'(len));
        chk(16'h5082 + {{8{b[7]}}, b[7:0]}, ea);
        b = {8'h00, md(16'h5181)};
        go(CAM_MODE_REL_IND, CAM_KIND_NORMAL, 1'b0, 16'h5180);
        b = {8'h00, md(b)};
        chk(16'h5182 + {{8{b[7]}}, b[7:0]}, ea);
    endtask
    task automatic t_rmw;
        go(CAM_MODE_LONG_DIR, CAM_KIND_NORMAL, 1'b1, 16'h6000);
        chk(16'h1, 16'(n_ill));
        go(CAM_MODE_LONG_IDX, CAM_KIND_NORMAL, 1'b1, 16'h6000);
        chk(16'h0, 16'(nrd));
        go(CAM_MODE_LONG_IND, CAM_KIND_NORMAL, 1'b1, 16'h6000);
        chk(16'h1, 16'(n_ill));
        go(CAM_MODE_SHORT_DIR, CAM_KIND_NORMAL, 1'b1, 16'h6000);
        chk(16'h0, 16'(n_ill));
    endtask
    task automatic t_power;
        go(CAM_MODE_INHERENT, CAM_KIND_SLEEP, 1'b0, 16'h7000);
        chk(16'h0, 16'(slp));
        chk(16'h6, 16'(n_pwr));
        chk(16'h0, 16'(busy));
        go(CAM_MODE_INHERENT, CAM_KIND_HALT, 1'b0, 16'h7001);
        chk(16'h0, 16'(oscs));
        chk(16'h6, 16'(n_pwr));
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        {rst, start, rmw, usey, irq, xr, yr, dly, pc} = {1'b1, 38'h0};
        mode = CAM_MODE_INHERENT;
        kind = CAM_KIND_NORMAL;
        {fails, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_plain;
        t_direct;
        t_indexed;
        t_indirect;
        t_relative;
        t_rmw;
        t_power;
        give_verdict;
    end
endmodule

// file: logic/cam_decode.sv
// Operand addressing decoder: instruction length and effective address
//
// Functional notes
// - Short direct and indirect forms address only 0000h to 00FFh, long forms the full 64 Kbyte space.
// - Read-modify-write instructions accept only short forms for a memory operand.
// - Inherent instructions are one byte long and fetch nothing after the opcode.
// - Immediate instructions are two bytes and the second byte is the operand value.
// - Short direct fetches one address byte, used as an address in 00 to FF.
// - Long direct fetches a two-byte address word reaching the whole space.
// - Indexed addresses are the unsigned sum of the chosen index register and offset.
// - No-offset indexed fetches nothing and uses the index register as the address.
// - The no-offset indexed form on the second index register is one byte longer.
// - Short indexed fetches one offset byte, giving addresses 00 up to 1FE.
// - Long indexed fetches a two-byte offset word and adds the index register.
// - Indirect forms use the byte after the opcode as a pointer address in memory.
// - Short indirect reads a one-byte pointer from page zero as a page-zero address.
// - Long indirect reads a two-byte pointer located in page zero, reaching 64 Kbyte.
// - Relative targets are the next-instruction address plus a signed displacement.
// - Wait-for-interrupt sleeps until an interrupt; halt stops the oscillator.
`timescale 1ns/100ps
module cam_decode
    import cam_pkg::*;
(
    input  wire logic                  CLK_I,
    input  wire logic                  SYS_RST_I,
    input  wire logic                  START_I,
    input  wire logic [15:0]           PC_I,
    input  wire cam_pkg::cam_mode_e    MODE_I,
    input  wire cam_pkg::cam_kind_e    KIND_I,
    input  wire logic                  RMW_I,
    input  wire logic                  USE_Y_I,
    input  wire logic [7:0]            X_I,
    input  wire logic [7:0]            Y_I,
    input  wire logic                  IRQ_I,
    output logic                       BUSY_O,
    output logic [15:0]                MEM_ADDR_O,
    output logic                       MEM_RD_O,
    input  wire logic                  MEM_ACK_I,
    input  wire logic [7:0]            MEM_DATA_I,
    output logic                       DONE_O,
    output logic                       ILLEGAL_O,
    output logic [2:0]                 LEN_O,
    output logic [15:0]                EA_O,
    output logic [7:0]                 OPERAND_O,
    output logic                       OPERAND_VLD_O,
    output logic [15:0]                NEXT_PC_O,
    output logic                       SLEEP_O,
    output logic                       OSC_STOP_O
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [6:0] {
        CAM_ST_IDLE   = 7'h01,
        CAM_ST_FETCH1 = 7'h02,
        CAM_ST_FETCH2 = 7'h04,
        CAM_ST_PTR1   = 7'h08,
        CAM_ST_PTR2   = 7'h10,
        CAM_ST_SLEEP  = 7'h20,
        CAM_ST_HALT   = 7'h40
    } cam_state_e;

    typedef struct packed {
        cam_state_e  st;
        cam_mode_e   mode;
        logic [15:0] pc;
        logic [7:0]  idx;
        logic        y_sel;
        logic [7:0]  b1;
        logic [7:0]  hi;
        logic [15:0] mem_addr;
        logic        mem_rd;
        logic        done;
        logic        illegal;
        logic [2:0]  len;
        logic [15:0] ea;
        logic [7:0]  opnd;
        logic        opnd_vld;
        logic [15:0] next_pc;
        logic        sleep;
        logic        osc_stop;
    } cam_regs_s;

    cam_regs_s r_q;
    cam_regs_s r_d;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [2:0] len_of(input cam_mode_e m, input logic y);
        logic [2:0] l;
        l = CAM_LEN_INHERENT;
        unique case (m)
            CAM_MODE_INHERENT:  l = CAM_LEN_INHERENT;
            CAM_MODE_IMMEDIATE: l = CAM_LEN_IMMEDIATE;
            CAM_MODE_SHORT_DIR: l = CAM_LEN_SHORT;
            CAM_MODE_LONG_DIR:  l = CAM_LEN_LONG;
            CAM_MODE_NOOFS_IDX: l = CAM_LEN_NO_OFFSET;
            CAM_MODE_SHORT_IDX: l = CAM_LEN_SHORT;
            CAM_MODE_LONG_IDX:  l = CAM_LEN_LONG;
            CAM_MODE_SHORT_IND: l = CAM_LEN_SHORT;
            CAM_MODE_LONG_IND:  l = CAM_LEN_SHORT;
            CAM_MODE_REL_DIR:   l = CAM_LEN_RELATIVE;
            CAM_MODE_REL_IND:   l = CAM_LEN_RELATIVE;
            default:            l = CAM_LEN_INHERENT;
        endcase
        // On the no-offset indexed form the second index register costs a selector byte ahead of the opcode
        if (y && m == CAM_MODE_NOOFS_IDX) begin
            l = l + CAM_LEN_Y_EXTRA;
        end
        return l;
    endfunction

    // Long forms of memory operands
    function automatic logic is_long(input cam_mode_e m);
        return (m == CAM_MODE_LONG_DIR) || (m == CAM_MODE_LONG_IDX)
            || (m == CAM_MODE_LONG_IND);
    endfunction

    // Page-zero address from one byte
    function automatic logic [15:0] page0(input logic [7:0] b);
        return {CAM_PAGE0_HIGH, b};
    endfunction

    // ************************************************************
    // Shared adder
    // ************************************************************
    logic [15:0] add_base;
    logic [15:0] add_off;
    cam_add_e    add_kind;
    logic [15:0] add_sum;

    cam_ea_add u_add (
        .base_i       (add_base),
        .off_i        (add_off),
        .kind_i       (add_kind),
        .sum_o        (add_sum),
        .page_cross_o ()
    );

    // Operand selection follows the state that consumes the sum
    always_comb begin
        add_base = {8'h00, r_q.idx};
        add_off  = {8'h00, MEM_DATA_I};
        add_kind = CAM_ADD_UBYTE;
        if (r_q.st == CAM_ST_FETCH1 && r_q.mode == CAM_MODE_REL_DIR) begin
            add_base = r_q.next_pc;
            add_kind = CAM_ADD_SBYTE;
        end else if (r_q.st == CAM_ST_PTR1 && r_q.mode == CAM_MODE_REL_IND) begin
            add_base = r_q.next_pc;
            add_kind = CAM_ADD_SBYTE;
        end else if (r_q.st == CAM_ST_FETCH2) begin
            add_off  = {r_q.b1, MEM_DATA_I};
            add_kind = CAM_ADD_WORD;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        r_d          = r_q;
        r_d.done     = 1'b0;
        r_d.illegal  = 1'b0;
        r_d.opnd_vld = 1'b0;

        unique case (r_q.st)
            CAM_ST_IDLE: begin
                if (START_I) begin
                    r_d.mode    = MODE_I;
                    r_d.pc      = PC_I;
                    r_d.y_sel   = USE_Y_I;
                    r_d.idx     = USE_Y_I ? Y_I : X_I;
                    r_d.len     = len_of(MODE_I, USE_Y_I);
                    r_d.next_pc = PC_I + 16'(len_of(MODE_I, USE_Y_I));
                    r_d.ea      = CAM_PAGE0_FIRST;
                    if (RMW_I && is_long(MODE_I)) begin
                        // Refused before any bus cycle is spent on it
                        r_d.done    = 1'b1;
                        r_d.illegal = 1'b1;
                    end else begin
                        unique case (MODE_I)
                            CAM_MODE_INHERENT: begin
                                if (KIND_I == CAM_KIND_SLEEP) begin
                                    r_d.st    = CAM_ST_SLEEP;
                                    r_d.sleep = 1'b1;
                                end else if (KIND_I == CAM_KIND_HALT) begin
                                    r_d.st       = CAM_ST_HALT;
                                    r_d.osc_stop = 1'b1;
                                end else begin
                                    r_d.done = 1'b1;
                                end
                            end
                            CAM_MODE_NOOFS_IDX: begin
                                r_d.ea   = page0(USE_Y_I ? Y_I : X_I);
                                r_d.done = 1'b1;
                            end
                            default: begin
                                r_d.st       = CAM_ST_FETCH1;
                                r_d.mem_addr = PC_I + CAM_OFS_BYTE1;
                                r_d.mem_rd   = 1'b1;
                            end
                        endcase
                    end
                end
            end

            CAM_ST_FETCH1: begin
                if (MEM_ACK_I) begin
                    r_d.b1     = MEM_DATA_I;
                    r_d.mem_rd = 1'b0;
                    r_d.st     = CAM_ST_IDLE;
                    unique case (r_q.mode)
                        CAM_MODE_IMMEDIATE: begin
                            r_d.opnd     = MEM_DATA_I;
                            r_d.opnd_vld = 1'b1;
                            r_d.done     = 1'b1;
                        end
                        CAM_MODE_SHORT_DIR: begin
                            r_d.ea   = page0(MEM_DATA_I);
                            r_d.done = 1'b1;
                        end
                        CAM_MODE_SHORT_IDX: begin
                            // Unsigned byte plus index tops out at 1FE
                            r_d.ea   = add_sum;
                            r_d.done = 1'b1;
                        end
                        CAM_MODE_LONG_DIR, CAM_MODE_LONG_IDX: begin
                            r_d.st       = CAM_ST_FETCH2;
                            r_d.mem_addr = r_q.pc + CAM_OFS_BYTE2;
                            r_d.mem_rd   = 1'b1;
                        end
                        CAM_MODE_SHORT_IND, CAM_MODE_LONG_IND,
                        CAM_MODE_REL_IND: begin
                            r_d.st       = CAM_ST_PTR1;
                            r_d.mem_addr = page0(MEM_DATA_I);
                            r_d.mem_rd   = 1'b1;
                        end
                        CAM_MODE_REL_DIR: begin
                            r_d.ea   = add_sum;
                            r_d.done = 1'b1;
                        end
                        default: begin
                            r_d.done = 1'b1;
                        end
                    endcase
                end
            end

            CAM_ST_FETCH2: begin
                if (MEM_ACK_I) begin
                    r_d.mem_rd = 1'b0;
                    r_d.st     = CAM_ST_IDLE;
                    r_d.done   = 1'b1;
                    if (r_q.mode == CAM_MODE_LONG_IDX) begin
                        r_d.ea = add_sum;
                    end else begin
                        r_d.ea = {r_q.b1, MEM_DATA_I};
                    end
                end
            end

            CAM_ST_PTR1: begin
                if (MEM_ACK_I) begin
                    r_d.mem_rd = 1'b0;
                    r_d.st     = CAM_ST_IDLE;
                    unique case (r_q.mode)
                        CAM_MODE_LONG_IND: begin
                            // Second pointer byte stays inside page zero
                            r_d.hi       = MEM_DATA_I;
                            r_d.st       = CAM_ST_PTR2;
                            r_d.mem_addr = page0(r_q.b1 + CAM_PTR_STEP);
                            r_d.mem_rd   = 1'b1;
                        end
                        CAM_MODE_REL_IND: begin
                            r_d.ea   = add_sum;
                            r_d.done = 1'b1;
                        end
                        default: begin
                            r_d.ea   = page0(MEM_DATA_I);
                            r_d.done = 1'b1;
                        end
                    endcase
                end
            end

            CAM_ST_PTR2: begin
                if (MEM_ACK_I) begin
                    r_d.mem_rd = 1'b0;
                    r_d.st     = CAM_ST_IDLE;
                    r_d.ea     = {r_q.hi, MEM_DATA_I};
                    r_d.done   = 1'b1;
                end
            end

            CAM_ST_SLEEP: begin
                // Only an interrupt leaves the low-power states
                if (IRQ_I) begin
                    r_d.sleep = 1'b0;
                    r_d.st    = CAM_ST_IDLE;
                    r_d.done  = 1'b1;
                end
            end

            CAM_ST_HALT: begin
                if (IRQ_I) begin
                    r_d.osc_stop = 1'b0;
                    r_d.st       = CAM_ST_IDLE;
                    r_d.done     = 1'b1;
                end
            end

            default: begin
                r_d.st       = CAM_ST_IDLE;
                r_d.mem_rd   = 1'b0;
                r_d.sleep    = 1'b0;
                r_d.osc_stop = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            r_q          <= '0;
            r_q.st       <= CAM_ST_IDLE;
            r_q.mode     <= CAM_MODE_INHERENT;
            r_q.len      <= CAM_LEN_INHERENT;
            r_q.ea       <= CAM_PAGE0_FIRST;
            r_q.mem_addr <= CAM_PAGE0_FIRST;
        end else begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign BUSY_O        = (r_q.st != CAM_ST_IDLE);
    assign MEM_ADDR_O    = r_q.mem_addr;
    assign MEM_RD_O      = r_q.mem_rd;
    assign DONE_O        = r_q.done;
    assign ILLEGAL_O     = r_q.illegal;
    assign LEN_O         = r_q.len;
    assign EA_O          = r_q.ea;
    assign OPERAND_O     = r_q.opnd;
    assign OPERAND_VLD_O = r_q.opnd_vld;
    assign NEXT_PC_O     = r_q.next_pc;
    assign SLEEP_O       = r_q.sleep;
    assign OSC_STOP_O    = r_q.osc_stop;

endmodule

// file: logic/cam_ea_add.sv
// Effective address adder: index, offset and branch displacement sums
`timescale 1ns/100ps
module cam_ea_add
    import cam_pkg::*;
(
    input  wire logic [15:0]      base_i,
    input  wire logic [15:0]      off_i,
    input  wire cam_pkg::cam_add_e kind_i,
    output logic      [15:0]      sum_o,
    output logic                  page_cross_o
);

    logic [15:0] ext;
    logic [16:0] full;

    // Byte offsets are zero or sign extended; words are taken whole
    always_comb begin
        unique case (kind_i)
            CAM_ADD_SBYTE: ext = {{8{off_i[7]}}, off_i[7:0]};
            CAM_ADD_WORD:  ext = off_i;
            default:       ext = {8'h00, off_i[7:0]};
        endcase
        full         = {1'b0, base_i} + {1'b0, ext};
        // Sum wraps inside the 64 Kbyte space
        sum_o        = full[15:0];
        page_cross_o = (full[15:8] != base_i[15:8]);
    end

endmodule

// file: logic/cam_pkg.sv
// Constants and types shared by the operand addressing decoder
package cam_pkg;

    // ************************************************************
    // Address space
    // ************************************************************
    localparam logic [15:0] CAM_PAGE0_FIRST = 16'h0000;
    localparam logic [15:0] CAM_PAGE0_LAST  = 16'h00FF;
    localparam logic [15:0] CAM_SHORT_IDX_LAST = 16'h01FE;
    localparam logic [7:0]  CAM_PAGE0_HIGH  = 8'h00;

    // ************************************************************
    // Instruction lengths in bytes, opcode included
    // ************************************************************
    localparam logic [2:0] CAM_LEN_INHERENT  = 3'h1;
    localparam logic [2:0] CAM_LEN_IMMEDIATE = 3'h2;
    localparam logic [2:0] CAM_LEN_SHORT     = 3'h2;
    localparam logic [2:0] CAM_LEN_LONG      = 3'h3;
    localparam logic [2:0] CAM_LEN_NO_OFFSET = 3'h1;
    localparam logic [2:0] CAM_LEN_Y_EXTRA   = 3'h1;
    localparam logic [2:0] CAM_LEN_RELATIVE  = 3'h2;

    // Offset of the first byte after the opcode, and of the second
    localparam logic [15:0] CAM_OFS_BYTE1 = 16'h0001;
    localparam logic [15:0] CAM_OFS_BYTE2 = 16'h0002;
    localparam logic [7:0]  CAM_PTR_STEP  = 8'h01;

    // ************************************************************
    // Addressing modes presented with each instruction
    // ************************************************************
    typedef enum logic [3:0] {
        CAM_MODE_INHERENT  = 4'h0,
        CAM_MODE_IMMEDIATE = 4'h1,
        CAM_MODE_SHORT_DIR = 4'h2,
        CAM_MODE_LONG_DIR  = 4'h3,
        CAM_MODE_NOOFS_IDX = 4'h4,
        CAM_MODE_SHORT_IDX = 4'h5,
        CAM_MODE_LONG_IDX  = 4'h6,
        CAM_MODE_SHORT_IND = 4'h7,
        CAM_MODE_LONG_IND  = 4'h8,
        CAM_MODE_REL_DIR   = 4'h9,
        CAM_MODE_REL_IND   = 4'hA
    } cam_mode_e;

    // Inherent operation kinds: normal, or special ones that change the power state
    typedef enum logic [1:0] {
        CAM_KIND_NORMAL = 2'h0,
        CAM_KIND_SLEEP  = 2'h1,
        CAM_KIND_HALT   = 2'h2
    } cam_kind_e;

    // How the adder treats its offset operand
    typedef enum logic [1:0] {
        CAM_ADD_UBYTE = 2'h0,
        CAM_ADD_SBYTE = 2'h1,
        CAM_ADD_WORD  = 2'h2
    } cam_add_e;

endpackage
